// File: charger_regs_cfg.svh
// offsets, reset values, field positions and timing counts of the bank
`ifndef CHARGER_REGS_CFG_SVH
`define CHARGER_REGS_CFG_SVH

`define ADDR_THR_R3_R2 8'h20
`define ADDR_THR_R4_R3 8'h21
`define ADDR_THR_R5_R4 8'h22
`define ADDR_THR_R6_R5 8'h23
`define ADDR_THR_R7_R6 8'h24
`define ADDR_VCODE_HI 8'h25
`define ADDR_VCODE_LO 8'h26
`define ADDR_ICODE_HI 8'h27
`define ADDR_ICODE_LO 8'h28
`define ADDR_OPTIONS 8'h29
`define ADDR_ABS_ADD 8'h2A
`define ADDR_ABS_LIM 8'h2B
`define ADDR_EQ_ADD 8'h2C
`define ADDR_EQ_TIME 8'h2D
`define ADDR_RECHARGE 8'h2E
`define ADDR_CHG_SEC 8'h30
`define ADDR_CV_SEC 8'h31
`define ADDR_ABS_SEC 8'h32
`define ADDR_EQ_SEC 8'h33

`define RST_THR_R3_R2 16'h372A
`define RST_THR_R4_R3 16'h1F27
`define RST_THR_R5_R4 16'h1BCC
`define RST_THR_R6_R5 16'h18B9
`define RST_THR_R7_R6 16'h136D
`define RST_VCODE_HI 16'h0000
`define RST_VCODE_LO 16'h0000
`define RST_ICODE_HI 16'h01EF
`define RST_ICODE_LO 16'h7FEF
`define RST_OPTIONS 16'h0000
`define RST_ABS_ADD 16'h0000
`define RST_ABS_LIM 16'h0000
`define RST_EQ_ADD 16'h002A
`define RST_EQ_TIME 16'h0E10
`define RST_RECHARGE 16'h4410

`define MASK_FULL 16'hFFFF
`define MASK_TWO_CODES 16'h03FF
`define MASK_THREE_CODES 16'h7FFF
`define MASK_OPTIONS 16'h0007
`define MASK_ADDER 16'h003F

`define OPT_CXTERM_BIT 2
`define OPT_TCOMP_BIT 1
`define OPT_PROFILE_BIT 0

`define CODE_W 5
`define CODE_A_LSB 0
`define CODE_B_LSB 5
`define CODE_C_LSB 10

`define CLK_HZ 10000000
`define SEC_PERIOD_S 1
`define SEC_TICK_CYCLES (`CLK_HZ * `SEC_PERIOD_S)
`define SEC_MAX 16'hFFFF

`endif

// File: charger_regs_pkg.sv
// types shared by the thermal profile and timer register bank
package charger_regs_pkg;
   typedef logic [15:0] word_t;
   typedef logic [4:0] code_t;
   typedef enum logic [2:0] {
      REGION_1, REGION_2, REGION_3, REGION_4, REGION_5, REGION_6, REGION_7
   } temp_region_t;
endpackage

// File: charger_thermal_profile_timer_regs.sv
// thermal profile thresholds, charge codes, options and phase timers
// Functional notes
// - writable region 3/2 threshold, default 0x372A
// - writable region 4/3 threshold, default 0x1F27
// - writable region 5/4 and 6/5 thresholds
// - writable region 7/6 threshold; region 7 off
// - region 6/5 voltage codes in one register
// - region 4/3/2 voltage codes in one register
// - region 6/5 current codes, reset 0x01EF
// - region 4/3/2 current codes, reset 0x7FEF
// - option bits 2:0, upper bits reserved
// - six-bit absorb voltage adder, rest reserved
// - equalize adder 0x002A, duration 0x0E10
// - writable sixteen-bit absorb time limit
// - recharge threshold register, reset 0x4410
// - read-only seconds counter while charging
// - read-only seconds counter in absorb phase
// - read-only seconds counter in equalize phase
// - timer termination after programmed constant-voltage seconds
// - region 1 off, beyond first threshold
`include "charger_regs_cfg.svh"
module charger_thermal_profile_timer_regs #(
   parameter int TICK_CYCLES = `SEC_TICK_CYCLES
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire charger_regs_pkg::word_t reg_wdata_i,
   output charger_regs_pkg::word_t reg_rdata_o,
   input wire charger_regs_pkg::word_t ntc_ratio_i,
   input wire charger_regs_pkg::word_t temp_threshold_r2_r1_i,
   input wire charger_regs_pkg::word_t cv_phase_time_limit_i,
   input wire logic [5:0] base_vcharge_i,
   input wire charger_regs_pkg::code_t base_icharge_i,
   input wire logic new_cycle_i,
   input wire logic charging_i,
   input wire logic cv_phase_i,
   input wire logic absorb_phase_i,
   input wire logic equalize_phase_i,
   output charger_regs_pkg::temp_region_t temp_region_o,
   output logic charge_off_o,
   output logic [5:0] vcharge_code_o,
   output charger_regs_pkg::code_t icharge_code_o,
   output logic cxterm_en_o,
   output logic temp_comp_en_o,
   output logic profile_en_o,
   output logic [5:0] absorb_adder_o,
   output charger_regs_pkg::word_t absorb_limit_o,
   output logic [5:0] equalize_adder_o,
   output charger_regs_pkg::word_t equalize_time_o,
   output charger_regs_pkg::word_t recharge_level_o,
   output logic timer_term_o
);
   import charger_regs_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   // saturating seconds counter; a new cycle wins over counting
   function automatic word_t sec_next(word_t cnt, logic run, logic tick,
                                      logic clr);
      word_t n;
      n = cnt;
      if (clr) begin
         n = '0;
      end else if (run && tick && cnt != `SEC_MAX) begin
         n = cnt + 16'h0001;
      end
      return n;
   endfunction

   // ---------------- configuration registers ----------------
   word_t thr2_reg, thr3_reg, thr4_reg, thr5_reg, thr6_reg;
   word_t thr2_next, thr3_next, thr4_next, thr5_next, thr6_next;
   word_t vhi_reg, vlo_reg, ihi_reg, ilo_reg, opt_reg;
   word_t vhi_next, vlo_next, ihi_next, ilo_next, opt_next;
   word_t aadd_reg, alim_reg, eadd_reg, etim_reg, rech_reg;
   word_t aadd_next, alim_next, eadd_next, etim_next, rech_next;

   always_comb begin
      thr2_next = thr2_reg;
      thr3_next = thr3_reg;
      thr4_next = thr4_reg;
      thr5_next = thr5_reg;
      thr6_next = thr6_reg;
      vhi_next = vhi_reg;
      vlo_next = vlo_reg;
      ihi_next = ihi_reg;
      ilo_next = ilo_reg;
      opt_next = opt_reg;
      aadd_next = aadd_reg;
      alim_next = alim_reg;
      eadd_next = eadd_reg;
      etim_next = etim_reg;
      rech_next = rech_reg;
      // reserved bits are masked off so they always read back as zero
      if (reg_wr_i) begin
         case (reg_addr_i)
            `ADDR_THR_R3_R2: thr2_next = reg_wdata_i;
            `ADDR_THR_R4_R3: thr3_next = reg_wdata_i;
            `ADDR_THR_R5_R4: thr4_next = reg_wdata_i;
            `ADDR_THR_R6_R5: thr5_next = reg_wdata_i;
            `ADDR_THR_R7_R6: thr6_next = reg_wdata_i;
            `ADDR_VCODE_HI: vhi_next = reg_wdata_i & `MASK_TWO_CODES;
            `ADDR_VCODE_LO: vlo_next = reg_wdata_i & `MASK_THREE_CODES;
            `ADDR_ICODE_HI: ihi_next = reg_wdata_i & `MASK_TWO_CODES;
            `ADDR_ICODE_LO: ilo_next = reg_wdata_i & `MASK_THREE_CODES;
            `ADDR_OPTIONS: opt_next = reg_wdata_i & `MASK_OPTIONS;
            `ADDR_ABS_ADD: aadd_next = reg_wdata_i & `MASK_ADDER;
            `ADDR_ABS_LIM: alim_next = reg_wdata_i;
            `ADDR_EQ_ADD: eadd_next = reg_wdata_i & `MASK_ADDER;
            `ADDR_EQ_TIME: etim_next = reg_wdata_i;
            `ADDR_RECHARGE: rech_next = reg_wdata_i;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         thr2_reg <= `RST_THR_R3_R2;
         thr3_reg <= `RST_THR_R4_R3;
         thr4_reg <= `RST_THR_R5_R4;
         thr5_reg <= `RST_THR_R6_R5;
         thr6_reg <= `RST_THR_R7_R6;
         vhi_reg <= `RST_VCODE_HI;
         vlo_reg <= `RST_VCODE_LO;
         ihi_reg <= `RST_ICODE_HI;
         ilo_reg <= `RST_ICODE_LO;
         opt_reg <= `RST_OPTIONS;
         aadd_reg <= `RST_ABS_ADD;
         alim_reg <= `RST_ABS_LIM;
         eadd_reg <= `RST_EQ_ADD;
         etim_reg <= `RST_EQ_TIME;
         rech_reg <= `RST_RECHARGE;
      end else begin
         thr2_reg <= thr2_next;
         thr3_reg <= thr3_next;
         thr4_reg <= thr4_next;
         thr5_reg <= thr5_next;
         thr6_reg <= thr6_next;
         vhi_reg <= vhi_next;
         vlo_reg <= vlo_next;
         ihi_reg <= ihi_next;
         ilo_reg <= ilo_next;
         opt_reg <= opt_next;
         aadd_reg <= aadd_next;
         alim_reg <= alim_next;
         eadd_reg <= eadd_next;
         etim_reg <= etim_next;
         rech_reg <= rech_next;
      end
   end

   // ---------------- seconds base and phase counters ----------------
   logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
   logic tick;
   word_t chg_sec_reg, cv_sec_reg, abs_sec_reg, eq_sec_reg;
   word_t chg_sec_next, cv_sec_next, abs_sec_next, eq_sec_next;
   logic term_reg, term_next;

   // the base restarts with each cycle so the first second is a full one
   assign tick = (tick_cnt_reg == TICK_LAST) && !new_cycle_i;

   always_comb begin
      tick_cnt_next = tick_cnt_reg + TW'(1);
      if (new_cycle_i || tick_cnt_reg == TICK_LAST) begin
         tick_cnt_next = '0;
      end
      chg_sec_next = sec_next(chg_sec_reg, charging_i, tick,
                              new_cycle_i);
      cv_sec_next = sec_next(cv_sec_reg, cv_phase_i, tick,
                             new_cycle_i);
      abs_sec_next = sec_next(abs_sec_reg, absorb_phase_i, tick,
                              new_cycle_i);
      eq_sec_next = sec_next(eq_sec_reg, equalize_phase_i, tick,
                             new_cycle_i);
      // stays set until the next charge cycle starts
      term_next = term_reg ||
                  (cv_phase_i && cv_sec_reg >= cv_phase_time_limit_i);
      if (new_cycle_i) begin
         term_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tick_cnt_reg <= '0;
         chg_sec_reg <= '0;
         cv_sec_reg <= '0;
         abs_sec_reg <= '0;
         eq_sec_reg <= '0;
         term_reg <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
         chg_sec_reg <= chg_sec_next;
         cv_sec_reg <= cv_sec_next;
         abs_sec_reg <= abs_sec_next;
         eq_sec_reg <= eq_sec_next;
         term_reg <= term_next;
      end
   end
   assign timer_term_o = term_reg;

   // ---------------- region decode and code selection ----------------
   temp_region_t region_reg, region_next;
   logic off_reg, off_next;
   logic [5:0] vout_reg, vout_next;
   code_t iout_reg, iout_next;
   word_t rdata_reg, rdata_next;

   // a larger ratio means a colder battery; ties go to the colder region
   always_comb begin
      if (ntc_ratio_i >= temp_threshold_r2_r1_i) begin
         region_next = REGION_1;
      end else if (ntc_ratio_i >= thr2_reg) begin
         region_next = REGION_2;
      end else if (ntc_ratio_i >= thr3_reg) begin
         region_next = REGION_3;
      end else if (ntc_ratio_i >= thr4_reg) begin
         region_next = REGION_4;
      end else if (ntc_ratio_i >= thr5_reg) begin
         region_next = REGION_5;
      end else if (ntc_ratio_i >= thr6_reg) begin
         region_next = REGION_6;
      end else begin
         region_next = REGION_7;
      end
      off_next = 1'b0;
      vout_next = base_vcharge_i;
      iout_next = base_icharge_i;
      if (opt_reg[`OPT_PROFILE_BIT]) begin
         case (region_next)
            REGION_2: begin
               vout_next = {1'b0, vlo_reg[`CODE_A_LSB +: `CODE_W]};
               iout_next = ilo_reg[`CODE_A_LSB +: `CODE_W];
            end
            REGION_3: begin
               vout_next = {1'b0, vlo_reg[`CODE_B_LSB +: `CODE_W]};
               iout_next = ilo_reg[`CODE_B_LSB +: `CODE_W];
            end
            REGION_4: begin
               vout_next = {1'b0, vlo_reg[`CODE_C_LSB +: `CODE_W]};
               iout_next = ilo_reg[`CODE_C_LSB +: `CODE_W];
            end
            REGION_5: begin
               vout_next = {1'b0, vhi_reg[`CODE_A_LSB +: `CODE_W]};
               iout_next = ihi_reg[`CODE_A_LSB +: `CODE_W];
            end
            REGION_6: begin
               vout_next = {1'b0, vhi_reg[`CODE_B_LSB +: `CODE_W]};
               iout_next = ihi_reg[`CODE_B_LSB +: `CODE_W];
            end
            default: begin
               // regions 1 and 7: charging stops, codes forced to zero
               off_next = 1'b1;
               vout_next = '0;
               iout_next = '0;
            end
         endcase
      end
      rdata_next = rdata_reg;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `ADDR_THR_R3_R2: rdata_next = thr2_reg;
            `ADDR_THR_R4_R3: rdata_next = thr3_reg;
            `ADDR_THR_R5_R4: rdata_next = thr4_reg;
            `ADDR_THR_R6_R5: rdata_next = thr5_reg;
            `ADDR_THR_R7_R6: rdata_next = thr6_reg;
            `ADDR_VCODE_HI: rdata_next = vhi_reg;
            `ADDR_VCODE_LO: rdata_next = vlo_reg;
            `ADDR_ICODE_HI: rdata_next = ihi_reg;
            `ADDR_ICODE_LO: rdata_next = ilo_reg;
            `ADDR_OPTIONS: rdata_next = opt_reg;
            `ADDR_ABS_ADD: rdata_next = aadd_reg;
            `ADDR_ABS_LIM: rdata_next = alim_reg;
            `ADDR_EQ_ADD: rdata_next = eadd_reg;
            `ADDR_EQ_TIME: rdata_next = etim_reg;
            `ADDR_RECHARGE: rdata_next = rech_reg;
            `ADDR_CHG_SEC: rdata_next = chg_sec_reg;
            `ADDR_CV_SEC: rdata_next = cv_sec_reg;
            `ADDR_ABS_SEC: rdata_next = abs_sec_reg;
            `ADDR_EQ_SEC: rdata_next = eq_sec_reg;
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         region_reg <= REGION_1;
         off_reg <= 1'b1;
         vout_reg <= '0;
         iout_reg <= '0;
         rdata_reg <= '0;
      end else begin
         region_reg <= region_next;
         off_reg <= off_next;
         vout_reg <= vout_next;
         iout_reg <= iout_next;
         rdata_reg <= rdata_next;
      end
   end

   assign temp_region_o = region_reg;
   assign charge_off_o = off_reg;
   assign vcharge_code_o = vout_reg;
   assign icharge_code_o = iout_reg;
   assign reg_rdata_o = rdata_reg;
   assign cxterm_en_o = opt_reg[`OPT_CXTERM_BIT];
   assign temp_comp_en_o = opt_reg[`OPT_TCOMP_BIT];
   assign profile_en_o = opt_reg[`OPT_PROFILE_BIT];
   assign absorb_adder_o = aadd_reg[5:0];
   assign absorb_limit_o = alim_reg;
   assign equalize_adder_o = eadd_reg[5:0];
   assign equalize_time_o = etim_reg;
   assign recharge_level_o = rech_reg;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   a_thr_readback: assert property (
      reg_wr_i && reg_addr_i == `ADDR_THR_R3_R2 ##1 !reg_wr_i ##1
      reg_rd_i && !reg_wr_i && reg_addr_i == `ADDR_THR_R3_R2
      |=> reg_rdata_o == $past(reg_wdata_i, 3))
      else $error("region 3/2 threshold did not read back");
   a_opt_reserved: assert property (
      reg_rd_i && reg_addr_i == `ADDR_OPTIONS |=> reg_rdata_o[15:3] == '0)
      else $error("reserved option bits read nonzero");
   a_cv_count_up: assert property (
      tick && cv_phase_i && cv_sec_reg != `SEC_MAX
      |=> cv_sec_reg == $past(cv_sec_reg) + 16'h0001)
      else $error("constant-voltage seconds did not advance");
   a_cv_hold_idle: assert property (
      !tick && !new_cycle_i |=> $stable(cv_sec_reg))
      else $error("constant-voltage seconds moved without a tick");
   a_chg_count_up: assert property (
      tick && charging_i && chg_sec_reg != `SEC_MAX
      |=> chg_sec_reg == $past(chg_sec_reg) + 16'h0001)
      else $error("charge seconds did not advance");
   a_abs_count_up: assert property (
      tick && absorb_phase_i && abs_sec_reg != `SEC_MAX
      |=> abs_sec_reg == $past(abs_sec_reg) + 16'h0001)
      else $error("absorb seconds did not advance");
   a_eq_count_up: assert property (
      tick && equalize_phase_i && eq_sec_reg != `SEC_MAX
      |=> eq_sec_reg == $past(eq_sec_reg) + 16'h0001)
      else $error("equalize seconds did not advance");
   a_counter_saturate: assert property (
      cv_sec_reg == `SEC_MAX && !new_cycle_i |=> cv_sec_reg == `SEC_MAX)
      else $error("constant-voltage seconds wrapped");
   a_new_cycle_clear: assert property (
      new_cycle_i |=> chg_sec_reg == '0 && cv_sec_reg == '0 &&
      abs_sec_reg == '0 && eq_sec_reg == '0 && !timer_term_o)
      else $error("counters not cleared by a new cycle");
   a_timer_term_set: assert property (
      cv_phase_i && cv_sec_reg >= cv_phase_time_limit_i && !new_cycle_i
      |=> timer_term_o)
      else $error("timer termination missed");
   a_region_cold_off: assert property (
      opt_reg[`OPT_PROFILE_BIT] && ntc_ratio_i >= temp_threshold_r2_r1_i
      |=> temp_region_o == REGION_1 && charge_off_o && icharge_code_o == '0)
      else $error("cold region did not stop charging");
   a_region_hot_off: assert property (
      opt_reg[`OPT_PROFILE_BIT] && ntc_ratio_i < thr6_reg &&
      ntc_ratio_i < temp_threshold_r2_r1_i
      |=> temp_region_o == REGION_7 && charge_off_o)
      else $error("hot region did not stop charging");
   a_region2_codes: assert property (
      opt_reg[`OPT_PROFILE_BIT] && region_next == REGION_2
      |=> icharge_code_o == $past(ilo_reg[4:0]) &&
      vcharge_code_o == {1'b0, $past(vlo_reg[4:0])})
      else $error("region 2 codes not applied");

   c_timer_term: cover property (!timer_term_o ##1 timer_term_o);
   c_saturate: cover property (chg_sec_reg == `SEC_MAX);
   c_region4: cover property (profile_en_o && temp_region_o == REGION_4);
   c_new_cycle: cover property (cv_sec_reg != '0 ##1 new_cycle_i);
endmodule

// File: host_model.sv
// host side of the register port: one strobe per request, released lines
module host_model (
   input wire logic clk_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output charger_regs_pkg::word_t reg_wdata_o,
   input wire charger_regs_pkg::word_t reg_rdata_i
);
   timeunit 1ns;
   timeprecision 1ns;
   import charger_regs_pkg::*;

   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 16'h0000;
   end

   // one idle edge before each request, so a strobe never toggles twice
   // in one time step; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input word_t d);
      @(posedge clk_i);
      #10;
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(posedge clk_i);
      #10;
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output word_t d);
      @(posedge clk_i);
      #10;
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(posedge clk_i);
      #10;
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      d = reg_rdata_i;
   endtask
endmodule

// File: test_charger_thermal_profile_timer_regs.sv
// self-checking bench for the thermal profile and timer register bank
`include "charger_regs_cfg.svh"
module test_charger_thermal_profile_timer_regs;
   timeunit 1ns;
   timeprecision 1ns;
   import charger_regs_pkg::*;

   localparam int TICK = 10;
   localparam word_t RST_TAB [20] = '{`RST_THR_R3_R2, `RST_THR_R4_R3,
      `RST_THR_R5_R4, `RST_THR_R6_R5, `RST_THR_R7_R6, `RST_VCODE_HI,
      `RST_VCODE_LO, `RST_ICODE_HI, `RST_ICODE_LO, `RST_OPTIONS,
      `RST_ABS_ADD, `RST_ABS_LIM, `RST_EQ_ADD, `RST_EQ_TIME, `RST_RECHARGE,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam word_t MASK_TAB [15] = '{16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'hFFFF, 16'h03FF, 16'h7FFF, 16'h03FF, 16'h7FFF,
      16'h0007, 16'h003F, 16'hFFFF, 16'h003F, 16'hFFFF, 16'hFFFF};
   localparam word_t RATIO_TAB [9] = '{16'h3F00, 16'h3EFF, 16'h372A,
      16'h3729, 16'h1F27, 16'h1F26, 16'h1BCB, 16'h18B8, 16'h136C};
   localparam int REGION_TAB [9] = '{0, 1, 1, 2, 2, 3, 4, 5, 6};

   logic clk_i, srst_i, reg_wr, reg_rd, new_cycle;
   logic charging, cv_phase, absorb, equalize;
   logic [7:0] reg_addr;
   word_t reg_wdata, reg_rdata, ntc_ratio, thr_r2_r1, cv_limit;
   logic [5:0] base_v, vcode, abs_add, eq_add;
   code_t base_i, icode;
   temp_region_t region;
   logic charge_off, cxterm, tcomp, prof, term;
   word_t abs_lim, eq_time, recharge;
   int fails = 0;
   int tests_run = 0;

   host_model host_model_i (.clk_i(clk_i), .reg_wr_o(reg_wr),
      .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
      .reg_rdata_i(reg_rdata));

   // short tick keeps each counted second at ten cycles
   charger_thermal_profile_timer_regs #(.TICK_CYCLES(TICK))
      charger_thermal_profile_timer_regs_i (.clk_i(clk_i), .srst_i(srst_i),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
      .ntc_ratio_i(ntc_ratio), .temp_threshold_r2_r1_i(thr_r2_r1),
      .cv_phase_time_limit_i(cv_limit), .base_vcharge_i(base_v),
      .base_icharge_i(base_i), .new_cycle_i(new_cycle),
      .charging_i(charging), .cv_phase_i(cv_phase),
      .absorb_phase_i(absorb), .equalize_phase_i(equalize),
      .temp_region_o(region), .charge_off_o(charge_off),
      .vcharge_code_o(vcode), .icharge_code_o(icode), .cxterm_en_o(cxterm),
      .temp_comp_en_o(tcomp), .profile_en_o(prof), .absorb_adder_o(abs_add),
      .absorb_limit_o(abs_lim), .equalize_adder_o(eq_add),
      .equalize_time_o(eq_time), .recharge_level_o(recharge),
      .timer_term_o(term));

   task automatic chk(input string name, input logic [15:0] got,
                      input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic results();
      if (fails == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic do_reset();
      @(posedge clk_i);
      #10;
      srst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #10;
      srst_i = 1'b0;
   endtask

   task automatic check_resets();
      word_t d;
      for (int i = 0; i < 20; i++) begin
         host_model_i.rd(8'h20 + 8'(i), d);
         chk("reset value", d, RST_TAB[i]);
      end
   endtask

   // all ones show which bits each register keeps; read-only places stay
   task automatic check_masks();
      word_t d;
      for (int i = 0; i < 15; i++) begin
         host_model_i.wr(8'h20 + 8'(i), 16'hFFFF);
         host_model_i.rd(8'h20 + 8'(i), d);
         chk("write mask", d, MASK_TAB[i]);
      end
      chk("absorb adder", {10'h000, abs_add}, 16'h003F);
      chk("absorb limit", abs_lim, 16'hFFFF);
      chk("equalize adder", {10'h000, eq_add}, 16'h003F);
      chk("equalize time", eq_time, 16'hFFFF);
      chk("recharge", recharge, 16'hFFFF);
      chk("options", {13'h0000, cxterm, tcomp, prof}, 16'h0007);
      for (int i = 0; i < 6; i++) begin
         host_model_i.wr(8'h2F + 8'(i), 16'hFFFF);
         host_model_i.rd(8'h2F + 8'(i), d);
         chk("read-only place", d, 16'h0000);
      end
      host_model_i.rd(8'h40, d);
      chk("unmapped", d, 16'h0000);
   endtask

   task automatic check_regions();
      int ev;
      do_reset();
      host_model_i.wr(`ADDR_OPTIONS, 16'h0001);
      host_model_i.wr(`ADDR_VCODE_LO, 16'h0C41);
      host_model_i.wr(`ADDR_VCODE_HI, 16'h00A4);
      host_model_i.wr(`ADDR_ICODE_LO, 16'h20E6);
      host_model_i.wr(`ADDR_ICODE_HI, 16'h0149);
      for (int i = 0; i < 9; i++) begin
         ntc_ratio = RATIO_TAB[i];
         repeat (2) @(posedge clk_i);
         #10;
         ev = (REGION_TAB[i] >= 1 && REGION_TAB[i] <= 5) ? REGION_TAB[i] : 0;
         chk("region", {13'h0000, region}, 16'(REGION_TAB[i]));
         chk("charge off", {15'h0000, charge_off},
             16'(REGION_TAB[i] == 0 || REGION_TAB[i] == 6));
         chk("voltage code", {10'h000, vcode}, 16'(ev));
         chk("current code", {11'h000, icode},
             16'(ev == 0 ? 0 : ev + 5));
      end
   endtask

   task automatic check_profile_off();
      base_v = 6'h2A;
      base_i = 5'h13;
      host_model_i.wr(`ADDR_OPTIONS, 16'h0006);
      repeat (2) @(posedge clk_i);
      #10;
      chk("options off", {13'h0000, cxterm, tcomp, prof}, 16'h0006);
      chk("charge off", {15'h0000, charge_off}, 16'h0000);
      chk("base voltage", {10'h000, vcode}, 16'h002A);
      chk("base current", {11'h000, icode}, 16'h0013);
   endtask

   task automatic check_timers();
      word_t d;
      @(posedge clk_i);
      #10;
      new_cycle = 1'b1;
      charging = 1'b1;
      cv_phase = 1'b1;
      absorb = 1'b1;
      @(posedge clk_i);
      #10;
      new_cycle = 1'b0;
      repeat (24) @(posedge clk_i);
      #10;
      chk("term early", {15'h0000, term}, 16'h0000);
      repeat (11) @(posedge clk_i);
      #10;
      // phases drop before the fourth tick, so the charge, cv and absorb counts stay at three
      charging = 1'b0;
      cv_phase = 1'b0;
      absorb = 1'b0;
      chk("term", {15'h0000, term}, 16'h0001);
      host_model_i.wr(`ADDR_CV_SEC, 16'hFFFF);
      for (int i = 0; i < 4; i++) begin
         host_model_i.rd(`ADDR_CHG_SEC + 8'(i), d);
         chk("seconds", d, i == 3 ? 16'h0000 : 16'h0003);
      end
      @(posedge clk_i);
      #10;
      new_cycle = 1'b1;
      equalize = 1'b1;
      @(posedge clk_i);
      #10;
      new_cycle = 1'b0;
      chk("term cleared", {15'h0000, term}, 16'h0000);
      repeat (24) @(posedge clk_i);
      #10;
      equalize = 1'b0;
      host_model_i.rd(`ADDR_EQ_SEC, d);
      chk("equalize seconds", d, 16'h0002);
      host_model_i.rd(`ADDR_CV_SEC, d);
      chk("cv cleared", d, 16'h0000);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   initial begin
      srst_i = 1'b1;
      ntc_ratio = 16'h136C;
      thr_r2_r1 = 16'h3F00;
      cv_limit = 16'h0003;
      base_v = 6'h00;
      base_i = 5'h00;
      new_cycle = 1'b0;
      charging = 1'b0;
      cv_phase = 1'b0;
      absorb = 1'b0;
      equalize = 1'b0;
      repeat (12) @(posedge clk_i);
      #10;
      srst_i = 1'b0;
      check_resets();
      check_masks();
      check_regions();
      check_profile_off();
      check_timers();
      results();
   end

   // a hang counts as a mismatch and still reaches the verdict
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      results();
   end
endmodule
